//--- core/ppp_pkg.sv
// How it works
// - entry refused when entry pins move within the qualify time after high level
// - last loaded command and address stay latched across many reads or writes
// - chip erase clears flash, sram, eeprom and lock bits, never fuse bits
// - lock bits cleared only after flash erase has completed
// - programmed eeprom preserve fuse keeps eeprom through chip erase
// - action select 10 with low byte select 0 and strobe rise loads command
// - command 1000 0000 means chip erase
// - command 0100 0000, data, write pulse programs fuse byte chosen by byte selects
// - command 0010 0000, data, write pulse programs lock bits where data is 0
// - lock bits return to unprogrammed only through chip erase
// - command 0000 0100, output enable low, selects 00 drives fuse low byte
// - in fuse read, output enable low, selects 11 drives fuse high byte
package ppp_pkg;
    localparam int CLK_MHZ = 200;
    localparam int QUAL_NS = 100;
    localparam int QUAL_CYC = (QUAL_NS * CLK_MHZ + 999) / 1000;
    localparam logic [2:0] MIN_STROBES = 3'h6;
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_FUSE = 8'h40;
    localparam logic [7:0] CMD_LOCK = 8'h20;
    localparam logic [7:0] CMD_READ_FUSE = 8'h04;
    localparam int EE_PRESERVE_BIT = 3;
    localparam logic [7:0] BYTE_ERASED = 8'hff;
    localparam logic [3:0] ENTRY_ZERO = 4'h0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_QUAL = 4'b0001,
        ST_FAIL = 4'b0010,
        ST_PROG = 4'b0011,
        ST_PGM_WAIT = 4'b0100,
        ST_ER_FLASH = 4'b0101,
        ST_ER_EE = 4'b0110,
        ST_ER_LOCK = 4'b0111
    } ppp_state_t;

    // parallel programming pins, sampled on mclk
    typedef struct packed {
        logic strobe;
        logic actHi;
        logic actLo;
        logic lowByteSel;
        logic highByteSel;
        logic wrN;
        logic oeN;
        logic [7:0] data;
    } ppp_pins_t;

    typedef struct packed {
        ppp_state_t st;
        logic [2:0] strobeCnt;
        logic strobeQ;
        logic wrQ;
        logic [3:0] entryQ;
        logic [15:0] timer;
        logic [1:0] pgmSel;
        logic [7:0] cmd;
        logic [15:0] addr;
        logic [7:0] dataLatch;
        logic [7:0] fuseLow;
        logic [7:0] fuseHigh;
        logic [7:0] lock;
        logic [7:0] dataOut;
        logic dataOeN;
        logic ready;
        logic progMode;
        logic eraseFlash;
        logic eraseSram;
        logic eraseEeprom;
    } ppp_regs_t;
endpackage

//--- core/ppp_port.sv
module ppp_port #(
    parameter logic [7:0] FUSE_LOW_INIT = 8'hff,
    parameter logic [7:0] FUSE_HIGH_INIT = 8'hff,
    parameter logic [7:0] LOCK_INIT = 8'hff,
    parameter logic [15:0] ERASE_CYCLES = 16'h0040,
    parameter logic [15:0] PROG_CYCLES = 16'h0010
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // reset pin qualifiers and entry pins
    input wire logic resetPinLow,
    input wire logic progHv,
    input wire logic [3:0] progEnable,
    // programming bus
    input wire ppp_pkg::ppp_pins_t pins,
    output logic [7:0] dataOut,
    output logic dataOeN,
    output logic readyBusyOut,
    // state seen by the memories
    output logic progMode,
    output logic eraseFlash,
    output logic eraseSram,
    output logic eraseEeprom,
    output logic [7:0] fuseLow,
    output logic [7:0] fuseHigh,
    output logic [7:0] lockBits,
    output logic [7:0] cmdLatched,
    output logic [15:0] addrLatched
);
    import ppp_pkg::*;

    ppp_regs_t s_r;
    ppp_regs_t s_nxt;
    logic strobeRise;
    logic wrFall;
    logic [1:0] act;

    // read mux feeding the registered output path; the checks compare the fuse registers directly
    function automatic logic [7:0] readByte(input ppp_regs_t r, input logic bs1, input logic bs2);
        logic [7:0] v;
        v = r.lock;
        if (!bs1 && !bs2) begin
            v = r.fuseLow;
        end else if (bs1 && bs2) begin
            v = r.fuseHigh;
        end
        return v;
    endfunction

    assign strobeRise = pins.strobe && !s_r.strobeQ;
    assign wrFall = !pins.wrN && s_r.wrQ;
    assign act = {pins.actHi, pins.actLo};

    // next state of the whole port
    always_comb begin
        s_nxt = s_r;
        s_nxt.strobeQ = pins.strobe;
        s_nxt.wrQ = pins.wrN;
        unique case (s_r.st)
            ST_IDLE: begin
                if (resetPinLow && strobeRise && s_r.strobeCnt < MIN_STROBES) begin
                    s_nxt.strobeCnt = s_r.strobeCnt + 3'h1;
                end
                // high level seen after enough strobes with entry pins at zero
                if (progHv && !resetPinLow && s_r.strobeCnt >= MIN_STROBES && progEnable == ENTRY_ZERO) begin
                    s_nxt.st = ST_QUAL;
                    s_nxt.timer = '0;
                    s_nxt.entryQ = progEnable;
                end else if (!resetPinLow) begin
                    s_nxt.strobeCnt = '0;
                end
            end
            ST_QUAL: begin
                if (!progHv || resetPinLow) begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.strobeCnt = '0;
                end else if (progEnable != s_r.entryQ) begin
                    s_nxt.st = ST_FAIL;
                end else if (s_r.timer == 16'(QUAL_CYC - 1)) begin
                    s_nxt.st = ST_PROG;
                    s_nxt.progMode = 1'b1;
                    s_nxt.ready = 1'b1;
                end else begin
                    s_nxt.timer = s_r.timer + 16'h1;
                end
            end
            // refused entry holds until reset goes low again
            ST_FAIL: begin
                if (resetPinLow) begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.strobeCnt = '0;
                end
            end
            ST_PROG: begin
                // loads only on strobe rise, so the latches persist between loads
                if (strobeRise) begin
                    unique case (act)
                        ACT_CMD: if (!pins.lowByteSel) s_nxt.cmd = pins.data;
                        ACT_ADDR: begin
                            if (pins.lowByteSel) begin
                                s_nxt.addr[15:8] = pins.data;
                            end else begin
                                s_nxt.addr[7:0] = pins.data;
                            end
                        end
                        ACT_DATA: s_nxt.dataLatch = pins.data;
                        default: ;
                    endcase
                end
                if (wrFall) begin
                    if (s_r.cmd == CMD_ERASE) begin
                        s_nxt.st = ST_ER_FLASH;
                        s_nxt.timer = '0;
                        s_nxt.ready = 1'b0;
                        s_nxt.eraseFlash = 1'b1;
                        s_nxt.eraseSram = 1'b1;
                    end else if (s_r.cmd == CMD_FUSE || s_r.cmd == CMD_LOCK) begin
                        s_nxt.st = ST_PGM_WAIT;
                        s_nxt.timer = '0;
                        s_nxt.ready = 1'b0;
                        s_nxt.pgmSel = {pins.lowByteSel, pins.highByteSel};
                    end
                end
            end
            // program delay; the target byte was fixed by the selects at the write edge
            ST_PGM_WAIT: begin
                if (s_r.timer == PROG_CYCLES - 16'h1) begin
                    s_nxt.st = ST_PROG;
                    s_nxt.ready = 1'b1;
                    if (s_r.cmd == CMD_LOCK) begin
                        s_nxt.lock = s_r.lock & s_r.dataLatch;
                    end else if (s_r.pgmSel == 2'h2) begin
                        s_nxt.fuseHigh = s_r.dataLatch;
                    end else if (s_r.pgmSel == 2'h0) begin
                        s_nxt.fuseLow = s_r.dataLatch;
                    end
                end else begin
                    s_nxt.timer = s_r.timer + 16'h1;
                end
            end
            ST_ER_FLASH: begin
                // flash and sram first; lock bits wait for flash to finish
                if (s_r.timer == ERASE_CYCLES - 16'h1) begin
                    s_nxt.eraseFlash = 1'b0;
                    s_nxt.eraseSram = 1'b0;
                    s_nxt.timer = '0;
                    if (s_r.fuseHigh[EE_PRESERVE_BIT]) begin
                        s_nxt.st = ST_ER_EE;
                        s_nxt.eraseEeprom = 1'b1;
                    end else begin
                        s_nxt.st = ST_ER_LOCK;
                    end
                end else begin
                    s_nxt.timer = s_r.timer + 16'h1;
                end
            end
            // eeprom phase runs only while the preserve fuse is left unprogrammed
            ST_ER_EE: begin
                if (s_r.timer == ERASE_CYCLES - 16'h1) begin
                    s_nxt.eraseEeprom = 1'b0;
                    s_nxt.st = ST_ER_LOCK;
                end else begin
                    s_nxt.timer = s_r.timer + 16'h1;
                end
            end
            // lock bits go last, so a cut erase never leaves an unlocked part with old flash
            ST_ER_LOCK: begin
                s_nxt.lock = BYTE_ERASED;
                s_nxt.st = ST_PROG;
                s_nxt.ready = 1'b1;
            end
            default: s_nxt.st = ST_IDLE;
        endcase
        // leaving programming mode aborts any operation not already in its last cycle; fuses are never touched here
        if (s_r.progMode && (resetPinLow || !progHv)) begin
            s_nxt.st = ST_IDLE;
            s_nxt.progMode = 1'b0;
            s_nxt.ready = 1'b0;
            s_nxt.strobeCnt = '0;
            s_nxt.eraseFlash = 1'b0;
            s_nxt.eraseSram = 1'b0;
            s_nxt.eraseEeprom = 1'b0;
        end
        // drive only for a fuse read with output enable low; contention-free otherwise
        s_nxt.dataOeN = !(s_r.progMode && !pins.oeN && s_r.cmd == CMD_READ_FUSE);
        s_nxt.dataOut = readByte(s_r, pins.lowByteSel, pins.highByteSel);
    end

    // single state register, synchronous reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.strobeQ <= 1'b0;
            s_r.wrQ <= 1'b1;
            s_r.fuseLow <= FUSE_LOW_INIT;
            s_r.fuseHigh <= FUSE_HIGH_INIT;
            s_r.lock <= LOCK_INIT;
            s_r.dataOeN <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // every output comes straight from the state register
    assign dataOut = s_r.dataOut;
    assign dataOeN = s_r.dataOeN;
    assign readyBusyOut = s_r.ready;
    assign progMode = s_r.progMode;
    assign eraseFlash = s_r.eraseFlash;
    assign eraseSram = s_r.eraseSram;
    assign eraseEeprom = s_r.eraseEeprom;
    assign fuseLow = s_r.fuseLow;
    assign fuseHigh = s_r.fuseHigh;
    assign lockBits = s_r.lock;
    assign cmdLatched = s_r.cmd;
    assign addrLatched = s_r.addr;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // a pin-driven exit overrides the state, mode, ready, strobe count and erase outputs the state machine chose in that cycle
    logic exitNow;
    assign exitNow = s_r.progMode && (resetPinLow || !progHv);

    // entry and latch checks
    a_entry_refused: assert property (
        (s_r.st == ST_QUAL && progHv && !resetPinLow && progEnable != s_r.entryQ) |=> s_r.st == ST_FAIL)
        else $error("entry pin change did not refuse entry");
    a_entry_qualified: assert property (
        $rose(progMode) |-> $past(s_r.st) == ST_QUAL && $past(s_r.timer) == 16'(QUAL_CYC - 1))
        else $error("programming mode entered without full qualify");
    a_cmd_load: assert property (
        (s_r.st == ST_PROG && !exitNow && strobeRise && act == ACT_CMD && !pins.lowByteSel)
        |=> cmdLatched == $past(pins.data))
        else $error("command byte not latched");
    a_cmd_held: assert property (
        !(s_r.st == ST_PROG && strobeRise && act == ACT_CMD) |=> $stable(cmdLatched))
        else $error("command changed without a load");
    a_addr_held: assert property (
        !(s_r.st == ST_PROG && strobeRise && act == ACT_ADDR) |=> $stable(addrLatched))
        else $error("address changed without a load");
    // erase sequencing, busy on write and fuse high programming
    a_erase_start: assert property (
        (s_r.st == ST_PROG && !exitNow && wrFall && s_r.cmd == CMD_ERASE)
        |=> s_r.st == ST_ER_FLASH && eraseFlash && !readyBusyOut)
        else $error("erase command did not start erase");
    a_fuse_kept: assert property (
        (s_r.st inside {ST_ER_FLASH, ST_ER_EE, ST_ER_LOCK}) |=> $stable(fuseLow) && $stable(fuseHigh))
        else $error("fuse changed during erase");
    a_lock_after_flash: assert property (
        eraseFlash |=> $stable(lockBits))
        else $error("lock cleared before flash erase done");
    a_ee_preserve: assert property (
        eraseEeprom |-> fuseHigh[EE_PRESERVE_BIT])
        else $error("eeprom erased with preserve fuse programmed");
    a_lock_no_clear: assert property (
        s_r.st != ST_ER_LOCK |=> (lockBits & ~$past(lockBits)) == 8'h00)
        else $error("lock bit cleared outside erase");
    a_busy_on_write: assert property (
        (s_r.st == ST_PROG && !exitNow && wrFall && (s_r.cmd == CMD_FUSE || s_r.cmd == CMD_LOCK))
        |=> !readyBusyOut [*2])
        else $error("ready did not drop for programming");
    a_fuse_high_prog: assert property (
        (s_r.st == ST_PGM_WAIT && !exitNow && s_r.cmd == CMD_FUSE && s_r.pgmSel == 2'h2
         && s_r.timer == PROG_CYCLES - 16'h1) |=> fuseHigh == $past(s_r.dataLatch) && readyBusyOut)
        else $error("fuse high byte not programmed");
    // read path and bus ownership
    a_read_low: assert property (
        (progMode && !pins.oeN && s_r.cmd == CMD_READ_FUSE && !pins.lowByteSel && !pins.highByteSel)
        |=> !dataOeN && dataOut == $past(s_r.fuseLow))
        else $error("fuse low byte not driven");
    a_bus_release: assert property (
        pins.oeN |=> dataOeN)
        else $error("bus driven with output enable high");
    a_bus_idle: assert property (
        !progMode |=> dataOeN)
        else $error("bus driven outside programming mode");

    // fuse high byte read with both selects high
    a_read_high: assert property (
        (progMode && !pins.oeN && s_r.cmd == CMD_READ_FUSE && pins.lowByteSel && pins.highByteSel)
        |=> !dataOeN && dataOut == $past(s_r.fuseHigh))
        else $error("fuse high byte not driven");

    // programming results land together with ready going high again
    a_fuse_low_prog: assert property (
        (s_r.st == ST_PGM_WAIT && !exitNow && s_r.cmd == CMD_FUSE && s_r.pgmSel == 2'h0
         && s_r.timer == PROG_CYCLES - 16'h1) |=> fuseLow == $past(s_r.dataLatch) && readyBusyOut)
        else $error("fuse low byte not programmed");
    a_lock_prog: assert property (
        (s_r.st == ST_PGM_WAIT && !exitNow && s_r.cmd == CMD_LOCK && s_r.timer == PROG_CYCLES - 16'h1)
        |=> lockBits == ($past(lockBits) & $past(s_r.dataLatch)))
        else $error("lock bits not programmed");

    // busy stands for the whole operation; a cut operation must still release everything
    a_busy_hold: assert property (
        s_r.st inside {ST_PGM_WAIT, ST_ER_FLASH, ST_ER_EE, ST_ER_LOCK} |-> !readyBusyOut)
        else $error("ready high while an operation runs");
    a_erase_done: assert property (
        (s_r.st == ST_ER_LOCK && !exitNow) |=> lockBits == BYTE_ERASED && readyBusyOut && s_r.st == ST_PROG)
        else $error("erase did not clear lock bits");
    a_mode_exit: assert property (
        exitNow |=> !progMode && !readyBusyOut && !eraseFlash && !eraseEeprom)
        else $error("programming mode not left");

    // main scenarios
    c_entry: cover property (s_r.st == ST_QUAL ##1 s_r.st == ST_PROG);
    c_erase_ee: cover property (eraseEeprom ##1 !eraseEeprom);
    c_fuse_read: cover property (!dataOeN && pins.highByteSel);
    c_lock_prog: cover property (s_r.st == ST_PGM_WAIT && s_r.cmd == CMD_LOCK ##1 s_r.st == ST_PROG);
    c_exit: cover property (progMode ##1 !progMode);
endmodule

//--- tb/ppp_programmer.sv
// behavioural external programmer; every pin moves just after a falling clock edge
module ppp_programmer (
    // clock
    input wire logic mclk,
    // pins toward the port
    output ppp_pkg::ppp_pins_t pins,
    output logic resetPinLow,
    output logic progHv,
    output logic [3:0] progEnable,
    // answers from the port
    input wire logic readyBusyOut,
    input wire logic dataOeN,
    input wire logic [7:0] dataOut
);
    timeunit 1ns;
    timeprecision 1ps;
    import ppp_pkg::*;

    // idle levels: reset pin low, write and output enable released
    initial begin
        pins = '{strobe: 1'b0, actHi: 1'b0, actLo: 1'b0, lowByteSel: 1'b0, highByteSel: 1'b0,
                 wrN: 1'b1, oeN: 1'b1, data: 8'h5a};
        resetPinLow = 1'b1;
        progHv = 1'b0;
        progEnable = 4'h9;
    end

    // six strobes under low reset, entry pins zeroed, wait, then high level; glitch breaks qualify
    task automatic enterMode(input logic glitch);
        repeat (6) begin
            @(negedge mclk) pins.strobe = 1'b1;
            @(negedge mclk) pins.strobe = 1'b0;
        end
        progEnable = ENTRY_ZERO;
        repeat (20) @(negedge mclk);
        resetPinLow = 1'b0;
        progHv = 1'b1;
        if (glitch) begin
            repeat (5) @(negedge mclk);
            progEnable = 4'h1;
        end
    endtask

    task automatic exitMode();
        @(negedge mclk);
        resetPinLow = 1'b1;
        progHv = 1'b0;
        progEnable = 4'h9;
        repeat (2) @(negedge mclk);
    endtask

    // one load; bus shows the inverse afterwards so no stale byte lingers
    task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] d);
        @(negedge mclk);
        {pins.actHi, pins.actLo} = act;
        pins.lowByteSel = bs;
        pins.data = d;
        pins.strobe = 1'b1;
        @(negedge mclk) pins.strobe = 1'b0;
        pins.data = ~d;
        @(negedge mclk);
    endtask

    // write pulse, then bounded wait for ready; busy sampled once the answer is due
    task automatic writePulse(input logic bl, input logic bh, output logic busy, output int cyc);
        @(negedge mclk);
        pins.lowByteSel = bl;
        pins.highByteSel = bh;
        pins.wrN = 1'b0;
        @(negedge mclk) pins.wrN = 1'b1;
        @(negedge mclk) busy = ~readyBusyOut;
        cyc = 2;
        while (readyBusyOut !== 1'b1 && cyc < 1000) begin
            @(negedge mclk);
            cyc++;
        end
        pins.lowByteSel = 1'b0;
        pins.highByteSel = 1'b0;
    endtask

    // read with output enable low, then release and look again
    task automatic readByte(input logic bl, input logic bh, output logic [7:0] q, output logic oeOn,
                            output logic oeOff);
        @(negedge mclk);
        pins.oeN = 1'b0;
        pins.lowByteSel = bl;
        pins.highByteSel = bh;
        repeat (2) @(negedge mclk);
        q = dataOut;
        oeOn = dataOeN;
        pins.oeN = 1'b1;
        repeat (2) @(negedge mclk);
        oeOff = dataOeN;
        pins.lowByteSel = 1'b0;
        pins.highByteSel = 1'b0;
    endtask
endmodule

//--- tb/ppp_port_tb.sv
module ppp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ppp_pkg::*;

    // short op times keep the run small
    localparam logic [15:0] PC = 16'h0004;
    localparam logic [15:0] EC = 16'h0004;
    logic mclk, rst_n, resetPinLow, progHv, readyBusyOut, dataOeN, progMode;
    logic eraseFlash, eraseSram, eraseEeprom, busy, oeA, oeB;
    logic [3:0] progEnable;
    logic [7:0] dataOut, fuseLow, fuseHigh, lockBits, cmdLatched, fl, fh, lk, d, q;
    logic [15:0] addrLatched;
    ppp_pins_t pins;
    int badCount, cmpCount, seed, flashCnt, eeCnt;

    ppp_port #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC)) ppp_port_i (.mclk(mclk), .rst_n(rst_n),
        .resetPinLow(resetPinLow), .progHv(progHv), .progEnable(progEnable), .pins(pins), .dataOut(dataOut),
        .dataOeN(dataOeN), .readyBusyOut(readyBusyOut), .progMode(progMode), .eraseFlash(eraseFlash),
        .eraseSram(eraseSram), .eraseEeprom(eraseEeprom), .fuseLow(fuseLow), .fuseHigh(fuseHigh),
        .lockBits(lockBits), .cmdLatched(cmdLatched), .addrLatched(addrLatched));
    ppp_programmer ppp_programmer_i (.mclk(mclk), .pins(pins), .resetPinLow(resetPinLow), .progHv(progHv),
        .progEnable(progEnable), .readyBusyOut(readyBusyOut), .dataOeN(dataOeN), .dataOut(dataOut));

    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic c1(input string nm, input logic e, input logic s);
        cmpCount++;
        if (s !== e) begin
            badCount++;
            $display("mismatch %s expected %b seen %b", nm, e, s);
        end
    endtask
    task automatic c8(input string nm, input logic [7:0] e, input logic [7:0] s);
        cmpCount++;
        if (s !== e) begin
            badCount++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cInt(input string nm, input int e, input int s);
        cmpCount++;
        if (s != e) begin
            badCount++;
            $display("mismatch %s expected %0d seen %0d", nm, e, s);
        end
    endtask

    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // write and check busy; expCyc 0 skips the timing figure (erase)
    task automatic doWrite(input logic bl, input logic bh, input int expCyc);
        int cyc;
        ppp_programmer_i.writePulse(bl, bh, busy, cyc);
        c1("busy after write", 1'b1, busy);
        if (expCyc > 0) cInt("write cycles", expCyc, cyc);
    endtask

    task automatic rd(input logic bl, input logic bh, input logic [7:0] e, input logic drive);
        ppp_programmer_i.readByte(bl, bh, q, oeA, oeB);
        c1("bus enable on read", ~drive, oeA);
        if (drive) c8("read data", e, q);
        c1("bus released", 1'b1, oeB);
    endtask

    // erase watcher: lock bits hold until the flash phase is over
    always @(negedge mclk) begin
        if (eraseFlash === 1'b1) begin
            flashCnt++;
            c8("lock during flash erase", lk, lockBits);
            c1("sram erased with flash", 1'b1, eraseSram);
        end
        if (eraseEeprom === 1'b1) eeCnt++;
    end

    // watchdog well past the expected few hundred cycles
    initial begin
        #200000;
        badCount++;
        wrapUp();
    end

    initial begin
        seed = 32'h7869736d;
        badCount = 0;
        cmpCount = 0;
        flashCnt = 0;
        eeCnt = 0;
        rst_n = 1'b0;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        c1("bus after reset", 1'b1, dataOeN);
        ppp_programmer_i.enterMode(1'b1);
        repeat (30) @(negedge mclk);
        c1("mode after entry glitch", 1'b0, progMode);
        ppp_programmer_i.exitMode();
        ppp_programmer_i.enterMode(1'b0);
        repeat (20) @(negedge mclk);
        c1("mode before qualify end", 1'b0, progMode);
        @(negedge mclk);
        c1("mode entered", 1'b1, progMode);
        c1("ready at entry", 1'b1, readyBusyOut);
        // address low and high byte loaded once each, window unchanged
        d = 8'($random(seed));
        ppp_programmer_i.load(ACT_ADDR, 1'b0, d);
        ppp_programmer_i.load(ACT_ADDR, 1'b1, ~d);
        c8("address low", d, addrLatched[7:0]);
        c8("address high", ~d, addrLatched[15:8]);
        fl = 8'hff;
        fh = 8'hff;
        lk = 8'hff;
        // pass 0 keeps eeprom through erase, pass 1 does not
        for (int it = 0; it < 2; it++) begin
            d = 8'($random(seed));
            ppp_programmer_i.load(ACT_CMD, 1'b0, CMD_FUSE);
            c8("command", CMD_FUSE, cmdLatched);
            ppp_programmer_i.load(ACT_DATA, 1'b0, d);
            doWrite(1'b0, 1'b0, PC + 1);
            fl = d;
            d = 8'($random(seed));
            d[EE_PRESERVE_BIT] = it[0];
            ppp_programmer_i.load(ACT_DATA, 1'b0, d);
            doWrite(1'b1, 1'b0, PC + 1);
            fh = d;
            c8("fuse low", fl, fuseLow);
            c8("fuse high", fh, fuseHigh);
            ppp_programmer_i.load(ACT_CMD, 1'b0, CMD_LOCK);
            for (int k = 0; k < 3; k++) begin
                d = (k == 2) ? 8'hff : 8'($random(seed));
                ppp_programmer_i.load(ACT_DATA, 1'b0, d);
                doWrite(1'b0, 1'b0, PC + 1);
                lk = lk & d;
                c8("lock bits", lk, lockBits);
            end
            rd(1'b0, 1'b0, 8'h00, 1'b0);
            ppp_programmer_i.load(ACT_CMD, 1'b0, CMD_READ_FUSE);
            rd(1'b0, 1'b0, fl, 1'b1);
            rd(1'b1, 1'b1, fh, 1'b1);
            rd(1'b1, 1'b0, lk, 1'b1);
            ppp_programmer_i.load(ACT_CMD, 1'b0, CMD_ERASE);
            flashCnt = 0;
            eeCnt = 0;
            doWrite(1'b0, 1'b0, 0);
            lk = 8'hff;
            cInt("flash erase cycles", EC, flashCnt);
            cInt("eeprom erase cycles", (it == 1) ? int'(EC) : 0, eeCnt);
            c8("lock after erase", lk, lockBits);
            c8("fuse low kept", fl, fuseLow);
            c8("fuse high kept", fh, fuseHigh);
        end
        // clock source fuses to zero on the erased part, then leave and come back in normally
        c8("locks still erased", 8'hff, lockBits);
        d = 8'($random(seed)) & 8'hf0;
        ppp_programmer_i.load(ACT_CMD, 1'b0, CMD_FUSE);
        ppp_programmer_i.load(ACT_DATA, 1'b0, d);
        doWrite(1'b0, 1'b0, PC + 1);
        ppp_programmer_i.exitMode();
        c1("mode left", 1'b0, progMode);
        c1("ready outside mode", 1'b0, readyBusyOut);
        ppp_programmer_i.enterMode(1'b0);
        repeat (21) @(negedge mclk);
        c1("mode re-entered", 1'b1, progMode);
        c8("clock source fuses", d, fuseLow);
        wrapUp();
    end
endmodule
